// file: rtl/cipher_mode_map.svh
`ifndef CIPHER_MODE_MAP_SVH
`define CIPHER_MODE_MAP_SVH

// Number of even-frame request transmissions before giving up.
`define REQ_ATTEMPTS 3'h5
`define FRAME_NUM_W 4
`define MFRAME_NUM_W 24
`define INIT_VALUE_W 35
`define KEY_W 64
`define LBN_FIRST 4'hf

`endif

// file: rtl/cipher_mode_pkg.sv
package cipher_mode_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ = 3'b001,
    ST_GRANT = 3'b010,
    ST_RELEASED = 3'b011
  } pt_state_t;

  typedef enum logic [1:0] {
    MSG_NONE = 2'b00,
    MSG_REQ = 2'b01,
    MSG_CONF = 2'b10,
    MSG_GRANT = 2'b11
  } mode_msg_t;
endpackage

// file: rtl/frame_iv_gen.sv
`include "cipher_mode_map.svh"

module frame_iv_gen (
  input wire logic i_clock, // System clock.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic i_frame_start, // One-cycle pulse at each frame start.
  input wire logic [`FRAME_NUM_W-1:0] i_frame_num, // Frame number of this frame.
  input wire logic [`MFRAME_NUM_W-1:0] i_mframe_num, // Multiframe number.
  input wire logic i_load, // Frame will be ciphered.
  output logic [`INIT_VALUE_W-1:0] o_init_value, // Init value for the generator.
  output logic o_reload // Generator reload pulse.
);
  wire [`INIT_VALUE_W-1:0] next_init_value = {7'h00, i_mframe_num, i_frame_num};

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_init_value <= '0;
      o_reload <= 1'b0;
    end else begin
      o_reload <= i_frame_start & i_load;
      if (i_frame_start & i_load) begin
        o_init_value <= next_init_value;
      end
    end
  end
endmodule

// file: rtl/cipher_mode_switch_ctrl.sv
// What this block does
// - Repeat stop request every even frame
// - Start request from next even, five tries
// - No start confirm: release, indicate disconnect
// - Decrypt from frame carrying first start confirm
// - Discard received data while awaiting confirm
// - Grant next even frame, then encrypt
// - Stop request from next even, five tries
// - No stop confirm: release, indicate disconnect
// - Stop decrypting at first stop confirm
// - Discard received data while awaiting confirm
// - Stop grant next even, then clear
// - Bearer handover keeps key and mode
// - Connection handover shares key stream
// - Restart ciphering after handover completes
// - Mode messages clear, parity restricted
// - Only this end initiates switches
// - Reload generator each ciphered frame
`include "cipher_mode_map.svh"

module cipher_mode_switch_ctrl (
  input wire logic i_clock, // 125 MHz clock.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic i_conn_reset, // Connection reset from the MAC, pulse.
  input wire logic i_frame_start, // One-cycle pulse at each frame start.
  input wire logic [`FRAME_NUM_W-1:0] i_frame_num, // Frame number.
  input wire logic [`MFRAME_NUM_W-1:0] i_mframe_num, // Multiframe number.
  input wire logic i_cipher_switch_request, // Upper-layer switch request pulse.
  input wire logic i_handover_restart, // Handover done after a clear interlude.
  input wire logic i_bearer_handover, // New bearer being established, pulse.
  input wire cipher_mode_pkg::mode_msg_t i_rx_msg, // Mode message decoded in rx frame.
  input wire logic i_rx_msg_valid, // Pulse: i_rx_msg is valid.
  output cipher_mode_pkg::mode_msg_t o_tx_msg, // Mode message to send this frame.
  output logic o_tx_msg_clear, // Mode message goes out unciphered.
  output logic o_tx_encrypt, // Encrypt transmitted fields.
  output logic o_rx_decrypt, // Decrypt received fields.
  output logic o_rx_discard, // Discard received B-field and user T data.
  output logic o_cipher_switch_confirm, // Pulse: confirm received.
  output logic o_link_release_indication, // Pulse: connection released.
  output logic o_bearer_encrypt, // Mode applied to a new bearer.
  output logic [`INIT_VALUE_W-1:0] o_init_value, // Generator init value.
  output logic o_kstream_reload // Generator reload pulse.
);
  import cipher_mode_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  pt_state_t state;
  pt_state_t next_state;
  logic ciphered; // Mode in force on this connection.
  logic stopping; // Current exchange switches to clear.
  logic pending; // Request waits for the next even frame.
  logic [2:0] attempts;

  function automatic logic is_even(input logic [`FRAME_NUM_W-1:0] fn);
    return ~fn[0];
  endfunction

  wire even_frame = i_frame_start & is_even(i_frame_num);
  wire odd_frame = i_frame_start & ~is_even(i_frame_num);
  wire conf_seen = i_rx_msg_valid & (i_rx_msg == MSG_CONF);
  wire tries_used = (attempts == `REQ_ATTEMPTS);
  // A restart after handover reuses the normal start procedure.
  wire want_switch = i_cipher_switch_request | (i_handover_restart & ~ciphered);
  wire start_req = (state == ST_IDLE) & (pending | want_switch) & even_frame;
  // A confirm that lands on the give-up frame still wins, so no release then.
  wire give_up = (state == ST_REQ) & even_frame & tries_used & ~conf_seen;
  wire send_grant = (state == ST_GRANT) & even_frame;
  wire cipher_next = send_grant ? ~stopping : ciphered;
  // The generator also runs through the request window of a start, so the
  // frame that carries the confirm can be deciphered at once.
  wire kstream_load = cipher_next | (state == ST_REQ);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start_req) next_state = ST_REQ;
      ST_REQ: begin
        if (conf_seen) next_state = ST_GRANT;
        else if (give_up) next_state = ST_RELEASED;
      end
      ST_GRANT: if (send_grant) next_state = ST_IDLE;
      ST_RELEASED: next_state = ST_RELEASED;
      default: next_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      ciphered <= 1'b0;
      stopping <= 1'b0;
      pending <= 1'b0;
      attempts <= 3'h0;
    end else if (i_conn_reset) begin
      state <= ST_IDLE;
      ciphered <= 1'b0;
      stopping <= 1'b0;
      pending <= 1'b0;
      attempts <= 3'h0;
    end else begin
      state <= next_state;
      ciphered <= cipher_next;
      if (state == ST_IDLE && want_switch && !start_req) begin
        pending <= 1'b1;
      end else if (start_req) begin
        pending <= 1'b0;
      end
      if (start_req) begin
        stopping <= ciphered;
        attempts <= 3'h1;
      end else if (state == ST_REQ && even_frame && !tries_used && !conf_seen) begin
        attempts <= attempts + 3'h1;
      end
    end
  end

  // Message drive and transmit encryption come from flops and change only at a
  // frame start or a connection reset; receive handling follows the confirm and indications are pulses.
  wire resend = (state == ST_REQ) & even_frame & ~tries_used & ~conf_seen;
  wire tx_req = start_req | resend;
  wire leave_odd = even_frame & ~tx_req & ~send_grant;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_msg <= MSG_NONE;
      o_tx_msg_clear <= 1'b1;
      o_tx_encrypt <= 1'b0;
      o_rx_decrypt <= 1'b0;
      o_rx_discard <= 1'b0;
      o_cipher_switch_confirm <= 1'b0;
      o_link_release_indication <= 1'b0;
      o_bearer_encrypt <= 1'b0;
    end else begin
      o_tx_msg_clear <= 1'b1;
      if (i_conn_reset || odd_frame || leave_odd) begin
        o_tx_msg <= MSG_NONE;
      end else if (tx_req) begin
        o_tx_msg <= MSG_REQ;
      end else if (send_grant) begin
        o_tx_msg <= MSG_GRANT;
      end
      if (i_conn_reset) begin
        o_tx_encrypt <= 1'b0;
      end else if (send_grant) begin
        o_tx_encrypt <= ~stopping;
      end
      if (i_conn_reset) begin
        o_rx_decrypt <= 1'b0;
      end else if (state == ST_REQ && conf_seen) begin
        o_rx_decrypt <= ~stopping;
      end
      o_rx_discard <= ~i_conn_reset & (start_req | (o_rx_discard & ~conf_seen));
      o_cipher_switch_confirm <= (state == ST_REQ) & conf_seen;
      o_link_release_indication <= give_up;
      if (i_bearer_handover) begin
        o_bearer_encrypt <= ciphered;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  frame_iv_gen u_iv (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_frame_start(i_frame_start),
    .i_frame_num(i_frame_num),
    .i_mframe_num(i_mframe_num),
    .i_load(kstream_load),
    .o_init_value(o_init_value),
    .o_reload(o_kstream_reload)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Even frames seen while requesting; the give-up frame makes it five.
  int unsigned frames_in_req;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) frames_in_req <= 0;
    else if (state != ST_REQ) frames_in_req <= 0;
    else if (even_frame) frames_in_req <= frames_in_req + 1;
  end

  AST_REQ_ONLY_EVEN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    odd_frame |=> o_tx_msg == MSG_NONE) else $error("mode message in odd frame");
  AST_START_FIRST_REQ: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    start_req && !i_conn_reset |=> o_tx_msg == MSG_REQ && state == ST_REQ)
    else $error("request not sent on even frame");
  AST_RELEASE_AFTER_FIVE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    give_up |=> o_link_release_indication && frames_in_req == 5)
    else $error("release not after five attempts");
  AST_DECRYPT_ON_CONF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_REQ && conf_seen && !stopping && !i_conn_reset |=> o_rx_decrypt)
    else $error("decrypt not on confirm");
  AST_DISCARD_WINDOW: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_REQ && !conf_seen && !i_conn_reset |=> o_rx_discard)
    else $error("data kept while awaiting confirm");
  AST_GRANT_ENCRYPT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    send_grant && !stopping && !i_conn_reset |=> o_tx_msg == MSG_GRANT && o_tx_encrypt)
    else $error("grant frame not encrypted");
  AST_STOP_CLEAR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    send_grant && stopping && !i_conn_reset |=> !o_tx_encrypt)
    else $error("grant frame still encrypted on stop");
  AST_STOP_DECRYPT_OFF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_REQ && conf_seen && stopping && !i_conn_reset |=> !o_rx_decrypt)
    else $error("decrypt not stopped on confirm");
  AST_CONFIRM_PULSE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_cipher_switch_confirm |-> $past(conf_seen && state == ST_REQ))
    else $error("stray confirm");
  AST_MSG_CLEAR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_tx_msg != MSG_NONE |-> o_tx_msg_clear) else $error("mode message ciphered");

  ////////////////////////////////////////////////////////////////////////////

  // Stop path, frame timing and key stream reloads. A missed reload would leave
  // both ends out of step without any visible error, hence the extra checks.
  AST_STOP_FIRST_REQ: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    start_req && ciphered && !i_conn_reset |=> o_tx_msg == MSG_REQ && stopping)
    else $error("stop request not sent on even frame");
  AST_STOP_RELEASE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    give_up && stopping && !i_conn_reset |=> o_link_release_indication)
    else $error("no release after stop attempts");
  AST_RESEND_EVEN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_REQ && even_frame && !tries_used && !conf_seen && !i_conn_reset
    |=> o_tx_msg == MSG_REQ) else $error("request not repeated");
  AST_CONF_ENDS_REQ: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_REQ && conf_seen && !i_conn_reset |=> state == ST_GRANT)
    else $error("confirm did not end requests");
  AST_GRANT_NEXT_EVEN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_GRANT && even_frame && !i_conn_reset |=> o_tx_msg == MSG_GRANT)
    else $error("grant not sent on next even frame");
  AST_DISCARD_ENDS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_REQ && conf_seen && !i_conn_reset |=> !o_rx_discard)
    else $error("data still discarded after confirm");
  AST_STOP_DISCARD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    start_req && ciphered && !i_conn_reset |=> o_rx_discard)
    else $error("data kept after stop request");
  AST_ENCRYPT_HOLDS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_tx_encrypt && !send_grant && !i_conn_reset |=> o_tx_encrypt)
    else $error("encryption dropped without grant");
  AST_CLEAR_HOLDS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_tx_encrypt && !send_grant && !i_conn_reset |=> !o_tx_encrypt)
    else $error("encryption raised without grant");
  AST_DECRYPT_HOLDS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_rx_decrypt && !(state == ST_REQ && conf_seen) && !i_conn_reset |=> o_rx_decrypt)
    else $error("decryption dropped without confirm");
  AST_MSG_HOLDS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_frame_start && !i_conn_reset |=> $stable(o_tx_msg))
    else $error("mode message changed inside a frame");
  AST_RELOAD_CIPHERED: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_frame_start && ciphered && !send_grant |=> o_kstream_reload)
    else $error("ciphered frame without reload");
  AST_RELOAD_IN_WINDOW: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_frame_start && state == ST_REQ |=> o_kstream_reload)
    else $error("no reload inside the request window");
  AST_GRANT_RELOAD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    send_grant && !stopping |=> o_kstream_reload)
    else $error("start grant frame not reloaded");
  AST_STOP_NO_RELOAD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    send_grant && stopping |=> !o_kstream_reload)
    else $error("stop grant frame still reloaded");
  AST_RELOAD_VALUE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_kstream_reload |-> o_init_value == {7'h00, $past(i_mframe_num), $past(i_frame_num)})
    else $error("wrong init value");
  AST_ATTEMPTS_CLEARED: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    start_req && !i_conn_reset |=> attempts == 3'h1)
    else $error("attempt count not restarted");
  AST_IDLE_WAITS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_IDLE && !start_req |=> state == ST_IDLE)
    else $error("switch started without a request");
  AST_RESTART_WHEN_CLEAR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_IDLE && even_frame && i_handover_restart && !ciphered && !i_conn_reset
    |=> state == ST_REQ && !stopping) else $error("handover restart ignored");
  AST_BEARER_MODE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_bearer_handover |=> o_bearer_encrypt == $past(ciphered))
    else $error("new bearer took the wrong mode");
  AST_RELEASE_FROZEN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_RELEASED && !i_conn_reset |=> state == ST_RELEASED && o_tx_msg == MSG_NONE)
    else $error("released link did not stay quiet");
  AST_RELEASE_PULSE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_link_release_indication |=> !o_link_release_indication)
    else $error("release indication longer than a cycle");
  AST_CONFIRM_ONE_CYCLE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_cipher_switch_confirm |=> !o_cipher_switch_confirm)
    else $error("confirm longer than a cycle");

  COV_START: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    send_grant && !stopping);
  COV_STOP: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    send_grant && stopping);
  COV_RELEASE: cover property (@(posedge i_clock) disable iff (!i_rst_n) give_up);
  COV_RESTART: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_IDLE && i_handover_restart && !ciphered);
  COV_LATE_CONF: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_REQ && conf_seen && tries_used);
endmodule

// file: testbench/ft_model.sv
`include "cipher_mode_map.svh"

module ft_model
  import cipher_mode_pkg::*;
(
  input wire logic i_clock, // System clock.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic i_conn_reset, // Connection reset pulse.
  input wire logic i_frame_start, // Frame start pulse.
  input wire logic [`FRAME_NUM_W-1:0] i_frame_num, // Frame number.
  input wire mode_msg_t i_tx_msg, // Message sent by the portable side.
  input wire logic [3:0] i_skip, // Odd frames left unanswered after a request.
  output mode_msg_t o_rx_msg, // Confirm towards the portable side.
  output logic o_rx_msg_valid // Qualifies o_rx_msg.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act;
  logic [3:0] cnt;
  logic [3:0] nc;
  assign nc = act ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act <= 1'b0;
      cnt <= 4'h0;
      o_rx_msg <= MSG_NONE;
      o_rx_msg_valid <= 1'b0;
    end else begin
      o_rx_msg_valid <= 1'b0;
      // The message lines toggle when unqualified so a stale value is never trusted.
      o_rx_msg <= mode_msg_t'(~o_rx_msg);
      if (i_conn_reset) begin
        act <= 1'b0;
      end else if (i_frame_start && i_frame_num[0]) begin
        if (i_tx_msg == MSG_GRANT || (!act && i_tx_msg != MSG_REQ)) begin
          act <= 1'b0;
        end else begin
          act <= 1'b1;
          cnt <= nc;
          if (nc >= i_skip && nc < 4'h6) begin
            o_rx_msg <= MSG_CONF;
            o_rx_msg_valid <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// file: testbench/cipher_mode_switch_ctrl_tb.sv
`include "cipher_mode_map.svh"

module cipher_mode_switch_ctrl_tb;
  import cipher_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRAME_LEN = 16;
  logic i_clock, i_rst_n, i_conn_reset, i_frame_start, i_cipher_switch_request;
  logic i_handover_restart, i_bearer_handover, i_rx_msg_valid, o_tx_msg_clear;
  logic o_tx_encrypt, o_rx_decrypt, o_rx_discard, o_cipher_switch_confirm;
  logic o_link_release_indication, o_bearer_encrypt, o_kstream_reload, was_fs;
  logic [`FRAME_NUM_W-1:0] i_frame_num;
  logic [`MFRAME_NUM_W-1:0] i_mframe_num;
  logic [`INIT_VALUE_W-1:0] o_init_value;
  logic [3:0] ft_skip;
  mode_msg_t i_rx_msg, o_tx_msg;
  int failures, checks_done, cyc, wd;

  cipher_mode_switch_ctrl u_dut (.i_clock, .i_rst_n, .i_conn_reset, .i_frame_start,
    .i_frame_num, .i_mframe_num, .i_cipher_switch_request, .i_handover_restart,
    .i_bearer_handover, .i_rx_msg, .i_rx_msg_valid, .o_tx_msg, .o_tx_msg_clear,
    .o_tx_encrypt, .o_rx_decrypt, .o_rx_discard, .o_cipher_switch_confirm,
    .o_link_release_indication, .o_bearer_encrypt, .o_init_value, .o_kstream_reload);
  ft_model u_ft (.i_clock, .i_rst_n, .i_conn_reset, .i_frame_start, .i_frame_num,
    .i_tx_msg(o_tx_msg), .i_skip(ft_skip), .o_rx_msg(i_rx_msg),
    .o_rx_msg_valid(i_rx_msg_valid));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge i_clock) begin
    wd++;
    if (wd == 6000) begin
      failures++;
      $display("BAD t=%0t run did not finish", $time);
      test_done();
    end
  end

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD t=%0t %s", $time, m);
    end
  endtask

  // One driver process for every input avoids same-step races between stimulus sources.
  task automatic tick(input logic [3:0] p);
    @(negedge i_clock);
    was_fs = i_frame_start;
    cyc++;
    {i_conn_reset, i_bearer_handover, i_handover_restart, i_cipher_switch_request} = p;
    i_frame_start = (cyc % FRAME_LEN == 0);
    if (i_frame_start) begin
      if (i_frame_num == 4'hf) i_mframe_num = i_mframe_num + 24'h1;
      i_frame_num = i_frame_num + 4'h1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic exchange(input logic [3:0] p, input logic [3:0] skip, input logic enc);
    int reqs;
    logic conf, rel, grant;
    reqs = 0;
    conf = 0;
    rel = 0;
    grant = 0;
    ft_skip = skip;
    tick(p);
    for (int n = 0; n < 400 && !rel && !grant; n++) begin
      tick(4'h0);
      if (was_fs && o_tx_msg === MSG_REQ) begin
        reqs++;
        chk(!i_frame_num[0] && o_rx_discard && o_tx_msg_clear, "request frame");
      end
      if (o_cipher_switch_confirm === 1'b1) begin
        conf = 1;
        chk(o_rx_decrypt === enc && o_rx_discard === 1'b0, "rx mode at confirm");
      end
      if (was_fs && o_tx_msg === MSG_GRANT) begin
        grant = 1;
        chk(!i_frame_num[0] && o_tx_encrypt === enc && o_kstream_reload === enc, "grant");
        if (enc) chk(o_init_value === {7'h0, i_mframe_num, i_frame_num}, "init value");
      end
      if (o_link_release_indication === 1'b1) rel = 1;
    end
    if (skip < 4'h5) chk(conf && grant && !rel && reqs == skip + 1, "exchange");
    else chk(rel && !conf && !grant && reqs == 5, "release");
    $display("exchange test done, %0d requests", reqs);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_conn_reset, i_frame_start, i_cipher_switch_request} = 3'h0;
    {i_handover_restart, i_bearer_handover} = 2'h0;
    i_frame_num = 4'hf;
    i_mframe_num = 24'h0005a3;
    ft_skip = 4'h0;
    i_rst_n = 1'b0;
    repeat (10) @(negedge i_clock);
    chk(o_tx_msg_clear === 1'b1 && o_tx_encrypt === 1'b0 && o_tx_msg === MSG_NONE, "reset");
    i_rst_n = 1'b1;
    exchange(4'h1, 4'h0, 1'b1);
    tick(4'h4);
    tick(4'h0);
    chk(o_bearer_encrypt === 1'b1, "bearer mode on");
    exchange(4'h1, 4'h2, 1'b0);
    tick(4'h4);
    tick(4'h0);
    chk(o_bearer_encrypt === 1'b0, "bearer mode off");
    exchange(4'h2, 4'h4, 1'b1);
    exchange(4'h1, 4'h7, 1'b0);
    tick(4'h8);
    tick(4'h0);
    chk(o_tx_encrypt === 1'b0 && o_rx_decrypt === 1'b0, "connection reset");
    exchange(4'h1, 4'h7, 1'b1);
    $display("all tests done");
    test_done();
  end
endmodule
